// ---- rtl/cdhi_pkg.sv ----
// package of constants and types for the character display host interface
package cdhi_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int TEXT_DEPTH = 80;
	localparam int GLYPH_DEPTH = 64;
	// register select / direction encodings
	localparam logic SEL_CMD = 1'h0;
	localparam logic SEL_DATA = 1'h1;
	localparam logic DIR_WRITE = 1'h0;
	localparam logic DIR_READ = 1'h1;
	// address map of the text memory
	localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
	localparam logic [6:0] LINE1_FIRST = 7'h00;
	localparam logic [6:0] LINE1_LAST = 7'h27;
	localparam logic [6:0] LINE2_FIRST = 7'h40;
	localparam logic [6:0] LINE2_LAST = 7'h67;
	localparam logic [6:0] EXT_FIRST_POS = 7'h08;
	// command decode: highest set bit among bits 7, 6, 5, 4 and 2 selects the command group
	localparam int CMD_TEXT_ADDR_BIT = 7;
	localparam int CMD_GLYPH_ADDR_BIT = 6;
	localparam int CMD_FUNC_BIT = 5;
	localparam int CMD_SHIFT_BIT = 4;
	localparam int CMD_MODE_BIT = 2;
	localparam int FUNC_WIDE_BIT = 4;
	localparam int FUNC_LINES_BIT = 3;
	localparam int SHIFT_DISP_BIT = 3;
	localparam int SHIFT_RIGHT_N_BIT = 2;
	localparam int MODE_INC_BIT = 1;
	localparam int MODE_SHIFT_BIT = 0;
	localparam logic [7:0] MSB_MASK = 8'h80;
	localparam logic [7:0] LOW_NIBBLE_MASK = 8'hF0;
	// time a command operation keeps the device busy
	localparam int OP_TIME_NS = 40000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OP_CYCLES = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAM_CYCLES = 4;

	typedef struct packed {
		logic register_select;
		logic read_write_select;
		logic [7:0] data;
	} cdhi_req_t;

	typedef struct packed {
		logic line_count_select;
		logic increment;
		logic shift_on_access;
		logic wide_font;
		logic bus_wide;
	} cdhi_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_FETCH = 3'b100
	} cdhi_state_t;
endpackage : cdhi_pkg

// ---- rtl/cdhi_host_port.sv ----
// host register port of the character display controller
`timescale 1ns/1ps
module cdhi_host_port (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic transfer_strobe,
	input wire logic register_select,
	input wire logic read_write_select,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic [7:0] data_oe_n,
	output logic busy_flag,
	output logic [6:0] display_origin,
	output logic [6:0] extension_origin,
	output logic line_count_select,
	output logic wide_font,
	output logic [7:0] shown_code
);
	// reset synchroniser
	logic rst_s1, rst_n;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	cdhi_pkg::cdhi_req_t req;
	assign req = '{register_select, read_write_select, data_in};

	// wrap a stepped address inside the active line range
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
		input logic two_line);
		logic [6:0] lo, hi;
		lo = cdhi_pkg::LINE1_FIRST;
		hi = cdhi_pkg::ONE_LINE_LAST;
		if (two_line) begin
			lo = a[6] ? cdhi_pkg::LINE2_FIRST : cdhi_pkg::LINE1_FIRST;
			hi = a[6] ? cdhi_pkg::LINE2_LAST : cdhi_pkg::LINE1_LAST;
		end
		if (up)
			step_addr = (a >= hi) ? lo : a + 7'h01;
		else
			step_addr = (a <= lo) ? hi : a - 7'h01;
	endfunction : step_addr

	// address shown at position 9: origin plus eight, wrapped inside the active line
	function automatic logic [6:0] ext_addr(input logic [6:0] a, input logic two_line);
		logic [6:0] lo, hi, sum;
		lo = cdhi_pkg::LINE1_FIRST;
		hi = cdhi_pkg::ONE_LINE_LAST;
		if (two_line) begin
			lo = a[6] ? cdhi_pkg::LINE2_FIRST : cdhi_pkg::LINE1_FIRST;
			hi = a[6] ? cdhi_pkg::LINE2_LAST : cdhi_pkg::LINE1_LAST;
		end
		sum = a + cdhi_pkg::EXT_FIRST_POS;
		if (sum > hi)
			sum = 7'(sum - 7'(hi - lo) - 7'h01); // past the line end wraps to its start
		ext_addr = sum;
	endfunction : ext_addr

	// storage
	logic [7:0] text_ram [cdhi_pkg::TEXT_DEPTH];
	logic [7:0] glyph_ram [cdhi_pkg::GLYPH_DEPTH];
	logic [7:0] command_register;
	logic [7:0] ram_data_register;
	logic [6:0] address_counter;
	logic target_glyph;
	cdhi_pkg::cdhi_mode_t mode;
	cdhi_pkg::cdhi_state_t state;
	logic [15:0] wait_cnt;
	logic nib_phase;
	logic [7:0] nib_hold;

	// strobe edge and nibble assembly; 4-bit mode uses the upper lines only
	logic strobe_d, take;
	logic [7:0] wbyte;
	logic full_take;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_d <= 1'b0;
			nib_phase <= 1'b0;
			nib_hold <= 8'h00;
		end else begin
			strobe_d <= transfer_strobe;
			if (take && !mode.bus_wide) begin
				nib_phase <= ~nib_phase;
				if (!nib_phase)
					nib_hold <= req.data & cdhi_pkg::LOW_NIBBLE_MASK;
			end
		end
	end
	assign take = transfer_strobe && !strobe_d;
	assign full_take = take && (mode.bus_wide || nib_phase);
	assign wbyte = mode.bus_wide ? req.data : {nib_hold[7:4], req.data[7:4]};

	logic is_cmd_wr, is_data_wr, is_data_rd;
	assign is_cmd_wr = full_take && req.register_select == cdhi_pkg::SEL_CMD
		&& req.read_write_select == cdhi_pkg::DIR_WRITE && state == cdhi_pkg::ST_IDLE;
	assign is_data_wr = full_take && req.register_select == cdhi_pkg::SEL_DATA
		&& req.read_write_select == cdhi_pkg::DIR_WRITE && state == cdhi_pkg::ST_IDLE;
	assign is_data_rd = full_take && req.register_select == cdhi_pkg::SEL_DATA
		&& req.read_write_select == cdhi_pkg::DIR_READ && state == cdhi_pkg::ST_IDLE;

	// busy sequencing: each command write, data write or data read runs an internal operation; status reads run none
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= cdhi_pkg::ST_IDLE;
			wait_cnt <= 16'h0000;
		end else begin
			unique case (state)
				cdhi_pkg::ST_IDLE: begin
					if (is_cmd_wr) begin
						state <= cdhi_pkg::ST_BUSY;
						wait_cnt <= 16'(cdhi_pkg::OP_CYCLES - 1);
					end else if (is_data_wr || is_data_rd) begin
						state <= cdhi_pkg::ST_FETCH;
						wait_cnt <= 16'(cdhi_pkg::RAM_CYCLES - 1);
					end
				end
				cdhi_pkg::ST_BUSY, cdhi_pkg::ST_FETCH: begin
					if (wait_cnt == 16'h0000)
						state <= cdhi_pkg::ST_IDLE;
					else
						wait_cnt <= wait_cnt - 16'h0001;
				end
				default: state <= cdhi_pkg::ST_IDLE;
			endcase
		end
	end

	// command decode: address loads, mode and function settings, shifts
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			command_register <= 8'h00;
			target_glyph <= 1'b0;
			mode <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
			display_origin <= 7'h00;
		end else begin
			if (is_cmd_wr) begin
				command_register <= wbyte;
				if (wbyte[cdhi_pkg::CMD_TEXT_ADDR_BIT]) begin
					target_glyph <= 1'b0;
				end else if (wbyte[cdhi_pkg::CMD_GLYPH_ADDR_BIT]) begin
					target_glyph <= 1'b1;
				end else if (wbyte[cdhi_pkg::CMD_FUNC_BIT]) begin
					mode.bus_wide <= wbyte[cdhi_pkg::FUNC_WIDE_BIT];
					mode.line_count_select <= wbyte[cdhi_pkg::FUNC_LINES_BIT];
					mode.wide_font <= wbyte[2];
				end else if (wbyte[cdhi_pkg::CMD_SHIFT_BIT]) begin
					if (wbyte[cdhi_pkg::SHIFT_DISP_BIT])
						display_origin <= step_addr(display_origin,
							wbyte[cdhi_pkg::SHIFT_RIGHT_N_BIT] == 1'b0,
							mode.line_count_select);
				end else if (wbyte[cdhi_pkg::CMD_MODE_BIT]) begin
					mode.increment <= wbyte[cdhi_pkg::MODE_INC_BIT];
					mode.shift_on_access <= wbyte[cdhi_pkg::MODE_SHIFT_BIT];
				end
			end else if (is_data_wr && mode.shift_on_access && !target_glyph) begin
				display_origin <= step_addr(display_origin, mode.increment,
					mode.line_count_select);
			end
		end
	end

	// address counter: loaded by address commands, stepped after each data write or data read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			address_counter <= 7'h00;
		end else if (is_cmd_wr && wbyte[cdhi_pkg::CMD_TEXT_ADDR_BIT]) begin
			address_counter <= wbyte[6:0];
		end else if (is_cmd_wr && wbyte[cdhi_pkg::CMD_GLYPH_ADDR_BIT]) begin
			address_counter <= {1'b0, wbyte[5:0]};
		end else if (is_data_wr || is_data_rd) begin
			if (target_glyph)
				address_counter <= {1'b0, 6'(address_counter[5:0]
					+ (mode.increment ? 6'h01 : 6'h3F))};
			else
				address_counter <= mode.increment ? address_counter + 7'h01
					: address_counter - 7'h01;
		end
	end

	// memory index, text addresses folded into 0..79 per line layout
	function automatic logic [6:0] text_index(input logic [6:0] a);
		text_index = (a >= cdhi_pkg::LINE2_FIRST) ? 7'(a - 7'h18) : a;
		if (text_index >= 7'(cdhi_pkg::TEXT_DEPTH))
			text_index = 7'(text_index - 7'(cdhi_pkg::TEXT_DEPTH));
	endfunction : text_index

	// data register and memory transfers, routed by recorded target
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ram_data_register <= 8'h00;
		end else if (is_data_wr) begin
			ram_data_register <= wbyte;
		end else if (is_data_rd) begin
			ram_data_register <= target_glyph ? glyph_ram[address_counter[5:0]]
				: text_ram[text_index(address_counter)];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (is_data_wr) begin
			if (target_glyph)
				glyph_ram[address_counter[5:0]] <= wbyte;
			else
				text_ram[text_index(address_counter)] <= wbyte;
		end
	end

	// read-back bus: status for select 0 (never the command), data for 1
	logic [7:0] rd_byte;
	assign rd_byte = (register_select == cdhi_pkg::SEL_CMD)
		? {busy_flag, address_counter} : ram_data_register;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 8'h00;
			data_oe_n <= 8'hFF;
			busy_flag <= 1'b0;
		end else begin
			busy_flag <= (state != cdhi_pkg::ST_IDLE) || is_cmd_wr
				|| is_data_wr || is_data_rd;
			if (transfer_strobe && read_write_select == cdhi_pkg::DIR_READ) begin
				data_out <= (mode.bus_wide || !nib_phase) ? rd_byte
					: {rd_byte[3:0], 4'h0};
				data_oe_n <= mode.bus_wide ? 8'h00 : 8'h0F;
			end else begin
				data_out <= 8'h00;
				data_oe_n <= 8'hFF;
			end
		end
	end

	// panel origin for extension driver positions 9-16; shown code at origin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			extension_origin <= 7'h00;
			line_count_select <= 1'b0;
			wide_font <= 1'b0;
			shown_code <= 8'h00;
		end else begin
			extension_origin <= ext_addr(display_origin, mode.line_count_select);
			line_count_select <= mode.line_count_select;
			wide_font <= mode.wide_font;
			shown_code <= text_ram[text_index(display_origin)];
		end
	end

	// assertions
	a_busy_ignores_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state != cdhi_pkg::ST_IDLE) |-> !is_cmd_wr) else $error("command taken while busy");
	a_busy_set_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
		is_cmd_wr |=> busy_flag) else $error("busy not raised");
	a_busy_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == cdhi_pkg::ST_FETCH) |-> ##[1:6] !busy_flag) else $error("busy stuck");
	a_addr_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(is_cmd_wr && wbyte[7]) |=> address_counter == $past(wbyte[6:0])) else $error("addr load");
	a_addr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(is_data_wr && !target_glyph && mode.increment) |=>
		address_counter == $past(address_counter) + 7'h01) else $error("no step");
	a_status_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(transfer_strobe && !register_select && read_write_select && mode.bus_wide) |=>
		data_out[6:0] == $past(address_counter)) else $error("status wrong");
	a_data_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		is_data_wr |=> ram_data_register == $past(wbyte)) else $error("data latch");
	a_narrow_lines: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!mode.bus_wide |=> data_oe_n[3:0] == 4'hF) else $error("low lines driven");

	// internal operation running means the flag reads high
	a_busy_while_op: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state != cdhi_pkg::ST_IDLE) |-> busy_flag)
		else $error("busy low during operation");

	// two idle cycles in a row leave the flag low
	a_idle_not_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == cdhi_pkg::ST_IDLE && $past(state) == cdhi_pkg::ST_IDLE) |-> !busy_flag)
		else $error("busy high while idle");

	// a finished data access returns to idle
	a_fetch_ends: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(state == cdhi_pkg::ST_FETCH && wait_cnt == 16'h0000) |=> state == cdhi_pkg::ST_IDLE)
		else $error("fetch does not end");

	// taken command byte lands in the command register
	a_cmd_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
		is_cmd_wr |=> command_register == $past(wbyte))
		else $error("command not stored");

	// glyph address command selects the glyph memory
	a_glyph_target: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(is_cmd_wr && !wbyte[7] && wbyte[6]) |=> target_glyph)
		else $error("glyph target not recorded");

	// glyph accesses keep the counter inside six bits
	a_glyph_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		((is_data_wr || is_data_rd) && target_glyph) |=> !address_counter[6])
		else $error("glyph counter out of range");

	// status read shows the busy flag on line 7 even while busy
	a_status_busy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(transfer_strobe && !register_select && read_write_select && mode.bus_wide) |=>
		data_out[7] == $past(busy_flag))
		else $error("status busy bit wrong");

	// data read returns the data register, never the command register
	a_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(transfer_strobe && register_select && read_write_select && mode.bus_wide) |=>
		data_out == $past(ram_data_register))
		else $error("data read wrong");

	// lines released whenever no strobe is up
	a_lines_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!transfer_strobe |=> data_oe_n == 8'hFF)
		else $error("lines driven without strobe");

	// covers for the main scenarios
	c_cmd_write: cover property (@(posedge clk_sys) disable iff (!rst_n) is_cmd_wr);
	c_two_line: cover property (@(posedge clk_sys) disable iff (!rst_n) mode.line_count_select);
	c_data_write: cover property (@(posedge clk_sys) disable iff (!rst_n) is_data_wr);
	c_data_read: cover property (@(posedge clk_sys) disable iff (!rst_n) is_data_rd);
endmodule : cdhi_host_port

// ---- sim/cdhi_host_model.sv ----
// microprocessor model driving the parallel register port
`timescale 1ns/1ps
module cdhi_host_model (
	input wire logic clk_sys,
	output logic transfer_strobe,
	output logic register_select,
	output logic read_write_select,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic [7:0] data_oe_n
);
	initial begin
		transfer_strobe = 1'b0;
		register_select = 1'b0;
		read_write_select = 1'b0;
		data_in = 8'h00;
	end
	// one access: selects first, then a strobe held five cycles
	task xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q,
		output logic [7:0] oe);
		@(negedge clk_sys);
		register_select = rs;
		read_write_select = rw;
		data_in = rw ? ~data_in : d;
		@(negedge clk_sys);
		transfer_strobe = 1'b1;
		repeat (5) @(negedge clk_sys);
		q = data_out;
		oe = data_oe_n;
		transfer_strobe = 1'b0;
		data_in = ~data_in; // released lines do not keep the last value
	endtask : xfer
endmodule : cdhi_host_model

// ---- sim/tb_char_display_host_interface.sv ----
// self-checking bench for the host register port
`timescale 1ns/1ps
module tb_char_display_host_interface;
	logic clk_sys, nrst, transfer_strobe, register_select, read_write_select, busy_flag;
	logic line_count_select, wide_font;
	logic [7:0] data_in, data_out, data_oe_n, shown_code, q, oe;
	logic [6:0] display_origin, extension_origin;
	int fail_count, comparisons, seed, ac, inc, org, two, glyph, i;
	int mem [int];
	int gm [int];
	// free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	cdhi_host_port DUT (.clk_sys(clk_sys), .nrst(nrst), .transfer_strobe(transfer_strobe),
		.register_select(register_select), .read_write_select(read_write_select),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .busy_flag(busy_flag),
		.display_origin(display_origin), .extension_origin(extension_origin),
		.line_count_select(line_count_select), .wide_font(wide_font), .shown_code(shown_code));
	cdhi_host_model host (.clk_sys(clk_sys), .transfer_strobe(transfer_strobe),
		.register_select(register_select), .read_write_select(read_write_select),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task conclude;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	// status read: all eight lines driven
	task status(output logic [7:0] s);
		host.xfer(1'b0, 1'b1, 8'h00, s, oe);
		chk("status_oe", 8'h00, oe);
	endtask : status
	// poll until idle, then check the counter readback
	task wait_idle;
		logic [7:0] s;
		for (int n = 0; n < 1000; n++) begin
			status(s);
			if (s[7] === 1'b0) break;
		end
		chk("status", 8'(ac), s);
	endtask : wait_idle
	task step;
		ac = glyph ? (ac + (inc ? 1 : -1)) & 63 : (ac + (inc ? 1 : -1)) & 127;
	endtask : step
	// command write; poke sends a data write that must be ignored while busy
	task cmd(input logic [7:0] b, input bit poke);
		logic [7:0] s;
		host.xfer(1'b0, 1'b0, b, s, oe);
		status(s);
		chk("busy", 8'h80, s & 8'h80);
		if (b[7]) begin
			ac = b[6:0];
			glyph = 0;
		end else if (b[6]) begin
			ac = b[5:0];
			glyph = 1;
		end else if (b[5]) two = b[3];
		else if (b[4] && b[3]) org = b[2] ? (two ? (org + 39) % 40 : (org + 79) % 80)
			: (two ? (org + 1) % 40 : (org + 1) % 80);
		else if (b[2]) inc = b[1];
		if (poke) host.xfer(1'b1, 1'b0, 8'h5A, s, oe);
		wait_idle;
		chk("origin", 8'(org), {1'b0, display_origin});
		chk("ext", 8'(two ? (org + 8) % 40 : (org + 8) % 80), {1'b0, extension_origin});
		chk("lines", 8'(two), {7'h00, line_count_select});
		if (mem.exists(org)) chk("shown", 8'(mem[org]), shown_code);
	endtask : cmd
	task wr(input logic [7:0] b);
		host.xfer(1'b1, 1'b0, b, q, oe);
		if (glyph) gm[ac] = b;
		else mem[ac] = b;
		step;
		wait_idle;
	endtask : wr
	task rd;
		host.xfer(1'b1, 1'b1, 8'h00, q, oe);
		chk("read", 8'(glyph ? gm[ac] : mem[ac]), q);
		chk("read_oe", 8'h00, oe);
		step;
		wait_idle;
	endtask : rd
	// watchdog on the whole run
	initial begin
		#1000000;
		fail_count++;
		conclude;
	end
	initial begin
		nrst = 1'b0;
		seed = 63982;
		inc = 1;
		repeat (8) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("reset_oe", 8'hFF, data_oe_n);
		chk("reset_busy", 8'h00, {7'h00, busy_flag});
		cmd(8'hCE, 0);
		for (i = 0; i < 3; i++) wr(8'($random(seed)));
		cmd(8'hCE, 0);
		rd;
		rd;
		cmd(8'h04, 0);
		cmd(8'h85, 1);
		wr(8'($random(seed)));
		wr(8'($random(seed)));
		cmd(8'h06, 0);
		cmd(8'h40, 0);
		wr(8'($random(seed)));
		cmd(8'h40, 0);
		rd;
		cmd(8'h85, 0);
		rd;
		cmd(8'h1C, 0);
		cmd(8'h18, 0);
		cmd(8'h38, 0);
		chk("font", 8'h00, {7'h00, wide_font});
		cmd(8'h1C, 0);
		conclude;
	end
endmodule : tb_char_display_host_interface
